// File: phca_bridge.sv
// host bridge: selector and data ports on the processor side, configuration cycles on the bus
// assumes ioRead/ioWrite are single-cycle pulses on ref_clk and the bus clock is unrelated
`timescale 1ns/1ps

// Functional notes
// - 32-bit bus, 33 MHz, device/function addressed
// - bus 0 internal, 1 graphics, 2 slots
// - shared AD lines, address then data phases
// - burst: one address, implied +4 per dword
// - memory target decodes dword address, checks burst bits
// - i/o target decodes full byte address
// - three cycle kinds, each agent decodes itself
// - selector at 0CF8, read/write, dword only
// - data window at 0CFC, 8/16/32-bit access
// - selector layout: enable, reserved zero, fields
// - type code 00 local, 01 downstream bus
// - type 0: device number drives one line (devices 0-15 only; 16-31 drive none)
// - function number carried in the cycle
// - register index selects one config dword
// - config space 256 bytes, 64-byte header
// - targets show vendor and device identifiers
// - slot device numbers and lines per variant
// - graphics function hidden when card present
module phca_bridge
    import phca_pkg::*;
#(
    parameter int DEVSEL_LIMIT = DEVSEL_WAIT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic peripheral_bus_clock,
    phca_bus_if.host bus,
    input wire logic [15:0] ioAddr,
    input wire logic [1:0] ioSize,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [31:0] ioWrData,
    output logic [31:0] ioRdData,
    output logic ioDone,
    output logic ioBusy,
    input wire logic agpCardPresent
);

    typedef enum logic [3:0] {
        M_IDLE = 4'b0001,
        M_ADDR = 4'b0010,
        M_DATA = 4'b0100,
        M_TURN = 4'b1000
    } phca_mstate_type;

    // processor-side state
    logic [31:0] selector_r;
    logic busy_r;
    logic reqTgl_r;
    logic [3:0] cmd_r;
    logic [31:0] addrWord_r;
    logic [3:0] beN_r;
    logic [31:0] wrData_r;
    logic [1:0] shift_r;
    logic [1:0] size_r;
    logic [1:0] agpPipe_r;
    logic [2:0] donePipe_r;
    logic access;
    logic hitSel;
    logic hitData;
    logic [4:0] selDev;
    logic [7:0] selBus;
    logic [1:0] selType;
    logic hidden;
    logic launch;
    logic doneEvt;

    // bus-side state
    logic [1:0] rstPipe_r;
    logic [1:0] cePipe_r;
    logic [2:0] reqPipe_r;
    logic run;
    logic reqEvt;
    phca_mstate_type state_r;
    logic [2:0] waitCnt_r;
    logic doneTgl_r;
    logic [31:0] busRd_r;

    // ***********************************************
    // processor port decode
    // ***********************************************
    assign access = clkEn && (ioRead || ioWrite) && !busy_r;
    assign hitSel = (ioAddr == SEL_OFFSET) && (ioSize == SIZE_32);
    assign hitData = (ioAddr[15:2] == DATA_OFFSET[15:2]);
    assign selBus = selector_r[BUS_HI:BUS_LO];
    assign selDev = selector_r[DEV_HI:DEV_LO];
    assign selType = selector_r[1:0];
    // graphics function on its bus stays invisible behind an add-in card
    assign hidden = agpPipe_r[1] && (selType == CYCLE_TYPE1) && (selBus == BUS_GRAPHICS)
                    && (selDev == 5'd0);
    assign launch = access && hitData && selector_r[SEL_ENABLE_BIT] && !hidden
                    && ((selType == CYCLE_TYPE0) || (selType == CYCLE_TYPE1));
    assign doneEvt = donePipe_r[2] ^ donePipe_r[1];
    assign ioBusy = busy_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            agpPipe_r <= 2'b00;
            donePipe_r <= 3'b000;
        end else if (clkEn) begin
            agpPipe_r <= {agpPipe_r[0], agpCardPresent};
            donePipe_r <= {donePipe_r[1:0], doneTgl_r};
        end
    end

    // ***********************************************
    // selector register
    // ***********************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            selector_r <= SEL_RESET;
        end else if (access && ioWrite && hitSel) begin
            selector_r <= ioWrData & SEL_WRITE_MASK;
        end
    end

    // ***********************************************
    // request launch and completion
    // ***********************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            reqTgl_r <= 1'b0;
            cmd_r <= CMD_CFG_RD;
            addrWord_r <= 32'h0000_0000;
            beN_r <= 4'hF;
            wrData_r <= 32'h0000_0000;
            shift_r <= 2'd0;
            size_r <= SIZE_32;
        end else if (clkEn) begin
            if (launch) begin
                busy_r <= 1'b1;
                reqTgl_r <= !reqTgl_r;
                cmd_r <= {CMD_CFG_RD[3:1], ioWrite};
                if (selType == CYCLE_TYPE0) begin
                    addrWord_r <= idselLine(selDev) | {21'd0, selector_r[FN_HI:REG_LO], CYCLE_TYPE0};
                end else begin
                    addrWord_r <= {8'd0, selector_r[BUS_HI:REG_LO], CYCLE_TYPE1};
                end
                beN_r <= ~laneEnable(ioSize, ioAddr[1:0]);
                wrData_r <= ioWrData << {ioAddr[1:0], 3'b000};
                shift_r <= ioAddr[1:0];
                size_r <= ioSize;
            end else if (doneEvt) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ioRdData <= 32'h0000_0000;
            ioDone <= 1'b0;
        end else if (clkEn) begin
            ioDone <= (access && !launch) || (busy_r && doneEvt);
            if (busy_r && doneEvt) begin
                ioRdData <= (busRd_r >> {shift_r, 3'b000}) & sizeMask(size_r);
            end else if (access && ioRead && hitSel) begin
                ioRdData <= selector_r;
            end else if (access && ioRead) begin
                ioRdData <= sizeMask(ioSize);
            end
        end
    end

    // ***********************************************
    // bus-side synchronisers
    // ***********************************************
    always_ff @(posedge peripheral_bus_clock) begin
        rstPipe_r <= {rstPipe_r[0], rst_n};
        cePipe_r <= {cePipe_r[0], clkEn};
    end
    assign run = cePipe_r[1];
    assign reqEvt = reqPipe_r[2] ^ reqPipe_r[1];

    always_ff @(posedge peripheral_bus_clock) begin
        if (!rstPipe_r[1]) begin
            reqPipe_r <= 3'b000;
        end else if (run) begin
            reqPipe_r <= {reqPipe_r[1:0], reqTgl_r};
        end
    end

    // ***********************************************
    // bus master sequencing
    // ***********************************************
    always_ff @(posedge peripheral_bus_clock) begin
        if (!rstPipe_r[1]) begin
            state_r <= M_IDLE;
            waitCnt_r <= 3'd0;
            doneTgl_r <= 1'b0;
            busRd_r <= ALL_ONES;
        end else if (run) begin
            unique case (state_r)
                M_IDLE: begin
                    if (reqEvt) begin
                        state_r <= M_ADDR;
                    end
                end
                M_ADDR: begin
                    waitCnt_r <= 3'd0;
                    state_r <= M_DATA;
                end
                M_DATA: begin
                    waitCnt_r <= waitCnt_r + 3'd1;
                    if (!bus.trdyN && !bus.devselN) begin
                        busRd_r <= bus.ad;
                        doneTgl_r <= !doneTgl_r;
                        state_r <= M_TURN;
                    end else if (bus.devselN && (waitCnt_r == 3'(DEVSEL_LIMIT))) begin
                        busRd_r <= ALL_ONES;
                        doneTgl_r <= !doneTgl_r;
                        state_r <= M_TURN;
                    end
                end
                M_TURN: begin
                    state_r <= M_IDLE;
                end
            endcase
        end
    end

    // single-phase configuration cycles; one dword per data phase
    assign bus.frameN = (state_r != M_ADDR);
    assign bus.irdyN = (state_r != M_DATA);
    assign bus.adHostOe = (state_r == M_ADDR) || ((state_r == M_DATA) && cmd_r[0]);
    assign bus.adHost = (state_r == M_ADDR) ? addrWord_r : wrData_r;
    assign bus.cbeN = (state_r == M_ADDR) ? cmd_r : ((state_r == M_DATA) ? beN_r : 4'hF);

endmodule

// File: phca_pkg.sv
// shared constants, field positions and helper functions for the configuration bridge pair
// assumes both ends and the bench import this package
package phca_pkg;

    // ***********************************************
    // host-visible port offsets and selector fields
    // ***********************************************
    localparam logic [15:0] SEL_OFFSET = 16'h0CF8;
    localparam logic [15:0] DATA_OFFSET = 16'h0CFC;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam int SEL_ENABLE_BIT = 31;
    localparam logic [31:0] SEL_WRITE_MASK = 32'h80FF_FFFF;
    localparam int BUS_HI = 23;
    localparam int BUS_LO = 16;
    localparam int DEV_HI = 15;
    localparam int DEV_LO = 11;
    localparam int FN_HI = 10;
    localparam int FN_LO = 8;
    localparam int REG_HI = 7;
    localparam int REG_LO = 2;
    localparam logic [1:0] CYCLE_TYPE0 = 2'h0;
    localparam logic [1:0] CYCLE_TYPE1 = 2'h1;

    // ***********************************************
    // bus hierarchy and slot wiring
    // ***********************************************
    localparam logic [7:0] BUS_INTERNAL = 8'h00;
    localparam logic [7:0] BUS_GRAPHICS = 8'h01;
    localparam logic [7:0] BUS_SLOTS = 8'h02;
    localparam int IDSEL_BASE = 16;

    // ***********************************************
    // bus commands, sizes and timing
    // ***********************************************
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [31:0] BURST_STEP = 32'h0000_0004;
    localparam int CFG_SPACE_BYTES = 256;
    localparam int DEVSEL_WAIT = 5;

    // byte lanes used by an access of a given size at a given offset
    function automatic logic [3:0] laneEnable(input logic [1:0] size, input logic [1:0] off);
        logic [3:0] base;
        base = (size == SIZE_8) ? 4'h1 : (size == SIZE_16) ? 4'h3 : 4'hF;
        return 4'((base << off));
    endfunction

    // mask keeping the low bytes an access of a given size returns
    function automatic logic [31:0] sizeMask(input logic [1:0] size);
        return (size == SIZE_8) ? 32'h0000_00FF : (size == SIZE_16) ? 32'h0000_FFFF : ALL_ONES;
    endfunction

    // one-hot chip-select line for a device number, zero if it has no line
    function automatic logic [31:0] idselLine(input logic [4:0] dev);
        logic [31:0] line;
        line = 32'h0000_0000;
        if (dev <= 5'd15) begin
            line[IDSEL_BASE + int'(dev)] = 1'b1;
        end
        return line;
    endfunction

    // device number of an expansion slot on the slot bus, per board variant
    function automatic logic [4:0] slotDevice(input logic variant, input logic [1:0] slot);
        logic [4:0] dev;
        unique case (slot)
            2'd1: dev = variant ? 5'd4 : 5'd6;
            2'd2: dev = variant ? 5'd9 : 5'd7;
            default: dev = variant ? 5'd10 : 5'd8;
        endcase
        return dev;
    endfunction

    // merge write data into a word under active-low byte enables
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] beN);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (!beN[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

endpackage

// File: phca_bus_if.sv
// carrier for the multiplexed address/data bus between the bridge and one target
// assumes the bench resolves nothing: the shared lines are merged here from the enables
`timescale 1ns/1ps

interface phca_bus_if;
    logic [31:0] adHost;
    logic adHostOe;
    logic [31:0] adTgt;
    logic adTgtOe;
    logic [31:0] ad;
    logic [3:0] cbeN;
    logic frameN;
    logic irdyN;
    logic trdyN;
    logic devselN;

    // undriven lines float high through pull-ups
    assign ad = adHostOe ? adHost : (adTgtOe ? adTgt : 32'hFFFF_FFFF);

    modport host (output adHost, output adHostOe, output cbeN, output frameN, output irdyN,
                  input ad, input trdyN, input devselN);
    modport target (output adTgt, output adTgtOe, output trdyN, output devselN,
                    input ad, input cbeN, input frameN, input irdyN);
endinterface

// File: phca_target.sv
// bus target with a 256-byte configuration space, a memory window and an i/o word
// assumes rst_n and clkEn come from another domain and are synchronised here
`timescale 1ns/1ps

module phca_target
    import phca_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID = 16'h0A5C, // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h0C3E, // arbitrary value
    parameter logic VARIANT = 1'b0,
    parameter logic [1:0] SLOT = 2'd1,
    parameter logic [31:0] MEM_BASE = 32'h8000_0000,
    parameter int MEM_WORDS = 16,
    parameter logic [31:0] IO_BASE = 32'h0000_E000
) (
    input wire logic peripheral_bus_clock,
    input wire logic rst_n,
    input wire logic clkEn,
    phca_bus_if.target bus,
    output logic cfgWrPulse,
    output logic [5:0] cfgWrIndex,
    output logic [31:0] cfgWrData
);

    typedef enum logic [1:0] {T_IDLE = 2'b01, T_DATA = 2'b10} phca_tstate_type;
    typedef enum logic [1:0] {K_CFG, K_MEM, K_IO} phca_kind_type;
    localparam int CFG_WORDS = CFG_SPACE_BYTES / 4;
    localparam int MW = $clog2(MEM_WORDS);

    logic [1:0] rstPipe_r;
    logic [1:0] cePipe_r;
    logic run;
    phca_tstate_type state_r;
    phca_kind_type kind_r;
    logic rd_r;
    logic [31:0] addr_r;
    logic [31:0] rdData_r;
    logic [31:0] cfgMem [CFG_WORDS];
    logic [31:0] memArr [MEM_WORDS];
    logic [31:0] ioWord_r;
    logic [31:0] myIdsel;
    logic hitCfg;
    logic hitMem;
    logic hitIo;
    logic xfer;
    logic [31:0] nextAddr;

    // ***********************************************
    // pin synchronisers
    // ***********************************************
    always_ff @(posedge peripheral_bus_clock) begin
        rstPipe_r <= {rstPipe_r[0], rst_n};
        cePipe_r <= {cePipe_r[0], clkEn};
    end
    assign run = cePipe_r[1];

    function automatic logic [31:0] readWord(input phca_kind_type k, input logic [31:0] a);
        logic [31:0] w;
        w = ALL_ONES;
        unique case (k)
            K_CFG: w = (a[REG_HI:REG_LO] == 6'd0) ? {DEVICE_ID, VENDOR_ID} : cfgMem[a[REG_HI:REG_LO]];
            K_MEM: w = memArr[a[MW+1:2]];
            K_IO: w = ioWord_r;
            default: w = ALL_ONES;
        endcase
        return w;
    endfunction

    // ***********************************************
    // address decode
    // ***********************************************
    assign myIdsel = idselLine(slotDevice(VARIANT, SLOT));
    assign hitCfg = (bus.cbeN[3:1] == CMD_CFG_RD[3:1]) && ((bus.ad & myIdsel) != 32'h0000_0000)
                    && (bus.ad[1:0] == CYCLE_TYPE0);
    assign hitMem = (bus.cbeN[3:1] == CMD_MEM_RD[3:1]) && (bus.ad[1:0] == 2'b00)
                    && (bus.ad[31:2] >= MEM_BASE[31:2])
                    && (bus.ad[31:2] < 30'(MEM_BASE[31:2] + 30'(MEM_WORDS)));
    assign hitIo = (bus.cbeN[3:1] == CMD_IO_RD[3:1]) && (bus.ad >= IO_BASE)
                   && (bus.ad <= IO_BASE + 32'h0000_0003);

    assign xfer = (state_r == T_DATA) && !bus.irdyN;
    assign nextAddr = addr_r + BURST_STEP;

    // ***********************************************
    // transaction sequencing
    // ***********************************************
    always_ff @(posedge peripheral_bus_clock) begin
        if (!rstPipe_r[1]) begin
            state_r <= T_IDLE;
            kind_r <= K_CFG;
            rd_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            rdData_r <= 32'h0000_0000;
        end else if (run) begin
            unique case (state_r)
                T_IDLE: begin
                    if (!bus.frameN && (hitCfg || hitMem || hitIo)) begin
                        kind_r <= hitCfg ? K_CFG : (hitMem ? K_MEM : K_IO);
                        rd_r <= !bus.cbeN[0];
                        addr_r <= {bus.ad[31:2], 2'b00};
                        rdData_r <= readWord(hitCfg ? K_CFG : (hitMem ? K_MEM : K_IO), bus.ad);
                        state_r <= T_DATA;
                    end
                end
                T_DATA: begin
                    if (xfer) begin
                        addr_r <= nextAddr;
                        rdData_r <= readWord(kind_r, nextAddr);
                        if (bus.frameN) begin
                            state_r <= T_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ***********************************************
    // storage writes
    // ***********************************************
    always_ff @(posedge peripheral_bus_clock) begin
        if (run && xfer && !rd_r) begin
            unique case (kind_r)
                K_CFG: cfgMem[addr_r[REG_HI:REG_LO]] <= mergeBytes(cfgMem[addr_r[REG_HI:REG_LO]],
                                                                     bus.ad, bus.cbeN);
                K_MEM: memArr[addr_r[MW+1:2]] <= mergeBytes(memArr[addr_r[MW+1:2]], bus.ad, bus.cbeN);
                default: ;
            endcase
        end
    end

    always_ff @(posedge peripheral_bus_clock) begin
        if (!rstPipe_r[1]) begin
            ioWord_r <= 32'h0000_0000;
            cfgWrPulse <= 1'b0;
            cfgWrIndex <= 6'd0;
            cfgWrData <= 32'h0000_0000;
        end else if (run) begin
            cfgWrPulse <= xfer && !rd_r && (kind_r == K_CFG);
            if (xfer && !rd_r && (kind_r == K_CFG)) begin
                cfgWrIndex <= addr_r[REG_HI:REG_LO];
                cfgWrData <= bus.ad;
            end
            if (xfer && !rd_r && (kind_r == K_IO)) begin
                ioWord_r <= mergeBytes(ioWord_r, bus.ad, bus.cbeN);
            end
        end
    end

    assign bus.devselN = (state_r != T_DATA);
    assign bus.trdyN = (state_r != T_DATA);
    assign bus.adTgt = rdData_r;
    assign bus.adTgtOe = (state_r == T_DATA) && rd_r;

endmodule

// File: phca_bus_props.sv
// concurrent checks on the shared lines between bridge and target
// assumes the bench instantiates it beside the carrier, fed with its lines
`timescale 1ns/1ps

module phca_bus_props (
    input wire logic peripheral_bus_clock,
    input wire logic rst_n,
    input wire logic [31:0] ad,
    input wire logic adHostOe,
    input wire logic adTgtOe,
    input wire logic [3:0] cbeN,
    input wire logic frameN,
    input wire logic irdyN,
    input wire logic trdyN,
    input wire logic devselN
);
    // ***********************************************
    // bus phase checks
    // ***********************************************
    default clocking cb @(posedge peripheral_bus_clock); endclocking
    default disable iff (!rst_n);

    a_addr_one_clock: assert property ($fell(frameN) |=> frameN)
        else $error("address phase longer than one clock");
    a_data_follows: assert property ($fell(frameN) |=> !irdyN)
        else $error("no data phase after address phase");
    a_host_drives_addr: assert property (!frameN |-> adHostOe && !adTgtOe)
        else $error("address phase not driven by host alone");
    a_no_contention: assert property (!(adHostOe && adTgtOe))
        else $error("both ends drive the shared lines");
    a_idsel_onehot: assert property (!frameN && cbeN[3:1] == 3'b101 && ad[1:0] == 2'b00 |-> $onehot(ad[31:11]))
        else $error("type 0 cycle without exactly one select line");
    a_type1_format: assert property (!frameN && cbeN[3:1] == 3'b101 && ad[1:0] == 2'b01 |-> ad[31:24] == 8'h00)
        else $error("type 1 address upper byte not zero");
    a_cycle_ends: assert property ($fell(frameN) |-> ##[2:12] $rose(irdyN))
        else $error("cycle not ended within bound");
    a_lanes_active: assert property (!irdyN |-> cbeN != 4'hF)
        else $error("data phase with no byte lane enabled");
    a_xfer_single: assert property (!irdyN && !trdyN && !devselN |=> irdyN)
        else $error("host kept data phase after transfer");
endmodule

// File: pci_host_config_access_tb_top.sv
// top bench: bridge and target joined by the carrier, random config traffic
// assumes the design files and package are compiled first
`timescale 1ns/1ps

module pci_host_config_access_tb_top import phca_pkg::*;;
    // ***********************************************
    // clocks, design and checker
    // ***********************************************
    localparam logic [15:0] VID = 16'h5A11; // arbitrary value
    localparam logic [15:0] DID = 16'h3C07; // arbitrary value
    localparam logic [15:0] DP = 16'h0CFC;
    logic ref_clk = 1'b0;
    logic peripheral_bus_clock = 1'b0;
    logic rst_n, clkEn, ioWrite, ioRead, agpCardPresent, ioDone, ioBusy;
    logic [15:0] ioAddr;
    logic [1:0] ioSize, off;
    logic [31:0] ioWrData, ioRdData, rdv, lastAddr, d, e, wrDat;
    logic [5:0] idx, wrIdx;
    logic [7:0] b;
    int failures = 0;
    int tests_run = 0;
    int frames = 0;
    int f;
    integer seed = 88;

    always #25 ref_clk = ~ref_clk;
    // bus clock offset so its edges never meet the processor clock edges
    initial begin
        #1.7;
        forever #3 peripheral_bus_clock = ~peripheral_bus_clock;
    end

    phca_bus_if phca_bus_if_i ();
    phca_bridge #(.DEVSEL_LIMIT(2)) phca_bridge_i (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
        .peripheral_bus_clock(peripheral_bus_clock), .bus(phca_bus_if_i), .ioAddr(ioAddr), .ioSize(ioSize),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioDone(ioDone),
        .ioBusy(ioBusy), .agpCardPresent(agpCardPresent));
    phca_target #(.VENDOR_ID(VID), .DEVICE_ID(DID)) phca_target_i (.peripheral_bus_clock(peripheral_bus_clock),
        .rst_n(rst_n), .clkEn(clkEn), .bus(phca_bus_if_i), .cfgWrPulse(), .cfgWrIndex(wrIdx), .cfgWrData(wrDat));
    phca_bus_props phca_bus_props_i (.peripheral_bus_clock(peripheral_bus_clock), .rst_n(rst_n),
        .ad(phca_bus_if_i.ad), .adHostOe(phca_bus_if_i.adHostOe), .adTgtOe(phca_bus_if_i.adTgtOe),
        .cbeN(phca_bus_if_i.cbeN), .frameN(phca_bus_if_i.frameN), .irdyN(phca_bus_if_i.irdyN),
        .trdyN(phca_bus_if_i.trdyN), .devselN(phca_bus_if_i.devselN));

    always @(negedge phca_bus_if_i.frameN) frames++;
    always @(posedge peripheral_bus_clock) begin
        if (phca_bus_if_i.frameN === 1'b0) begin
            lastAddr <= phca_bus_if_i.ad;
        end
    end

    // ***********************************************
    // tasks
    // ***********************************************
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic io(input logic w, input logic [15:0] a, input logic [1:0] s, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        ioWrite <= w;
        ioRead <= !w;
        ioAddr <= a;
        ioSize <= s;
        ioWrData <= wd;
        @(posedge ref_clk);
        ioWrite <= 1'b0;
        ioRead <= 1'b0;
        @(negedge ref_clk);
        while (ioDone !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400) begin
            failures++;
            $display("[ERR] ioDone expected 1 seen %b", ioDone);
            results();
        end else begin
            rdv = ioRdData;
        end
    endtask

    // ***********************************************
    // scenarios
    // ***********************************************
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioAddr = 16'h0000;
        ioSize = 2'h2;
        ioWrData = 32'h0000_0000;
        agpCardPresent = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        io(1'b1, 16'h0CF8, 2'h2, 32'hFF00_3004);
        io(1'b0, 16'h0CF8, 2'h2, 32'h0);
        chk("selector", 32'h8000_3004, rdv);
        io(1'b1, 16'h0CF8, 2'h0, 32'h0);
        io(1'b0, 16'h0CF8, 2'h2, 32'h0);
        chk("selector byte write", 32'h8000_3004, rdv);
        io(1'b0, 16'h0CF0, 2'h2, 32'h0);
        chk("unmapped", 32'hFFFF_FFFF, rdv);
        $display("test selector done");
        io(1'b1, 16'h0CF8, 2'h2, 32'h8000_3000);
        f = frames;
        io(1'b0, DP, 2'h2, 32'h0);
        chk("ident", {DID, VID}, rdv);
        chk("ident cycles", 32'h1, 32'(frames - f));
        chk("select line", 32'h0040_0000, lastAddr & 32'hFFFF_F803);
        chk("busy", 32'h0, {31'h0, ioBusy});
        $display("test ident done");
        for (int i = 0; i < 6; i++) begin
            idx = 6'($unsigned($random(seed)) % 15 + 1);
            d = $random(seed);
            b = 8'($random(seed));
            off = 2'($random(seed));
            e = d;
            e[8*off +: 8] = b;
            io(1'b1, 16'h0CF8, 2'h2, {16'h8000, 5'd6, 3'd0, idx, 2'b00});
            io(1'b1, DP, 2'h2, d);
            chk("write index", {26'h0, idx}, {26'h0, wrIdx});
            io(1'b1, DP + 16'(off), 2'h0, {24'h0, b});
            chk("write data", {24'h0, b} << (8 * off), wrDat);
            io(1'b0, DP, 2'h2, 32'h0);
            chk("word", e, rdv);
            io(1'b0, DP + {14'h0, off[1], 1'b0}, 2'h1, 32'h0);
            chk("half", (e >> (16 * off[1])) & 32'h0000_FFFF, rdv);
        end
        $display("test random done");
        io(1'b1, 16'h0CF8, 2'h2, 32'h8000_3800);
        io(1'b0, DP + 16'h1, 2'h0, 32'h0);
        chk("abort byte", 32'h0000_00FF, rdv);
        io(1'b1, 16'h0CF8, 2'h2, 32'h8002_3001);
        f = frames;
        io(1'b0, DP, 2'h2, 32'h0);
        chk("type 1", 32'hFFFF_FFFF, rdv);
        chk("type 1 cycles", 32'h1, 32'(frames - f));
        chk("type 1 address", 32'h0002_3001, lastAddr);
        io(1'b1, 16'h0CF8, 2'h2, 32'h0000_3000);
        f = frames;
        io(1'b1, DP, 2'h2, 32'h0);
        io(1'b0, DP, 2'h2, 32'h0);
        chk("disabled", 32'hFFFF_FFFF, rdv);
        chk("disabled cycles", 32'h0, 32'(frames - f));
        $display("test abort done");
        @(posedge ref_clk);
        agpCardPresent <= 1'b1;
        repeat (4) @(posedge ref_clk);
        io(1'b1, 16'h0CF8, 2'h2, 32'h8001_0001);
        f = frames;
        io(1'b0, DP, 2'h2, 32'h0);
        chk("hidden", 32'hFFFF_FFFF, rdv);
        chk("hidden cycles", 32'h0, 32'(frames - f));
        @(posedge ref_clk);
        agpCardPresent <= 1'b0;
        repeat (4) @(posedge ref_clk);
        f = frames;
        io(1'b0, DP, 2'h2, 32'h0);
        chk("visible cycles", 32'h1, 32'(frames - f));
        $display("test graphics done");
        results();
    end
endmodule
